//--- hdl/mixed_length_fetch_decode_pkg.sv
// constants, maps and state codes for the mixed-length fetch and decode front end
// Function
// RULE1 - length comes from major opcode only
// RULE2 - major opcode picks minor field, immediate alignment
// RULE3 - big-endian: upper halfword first, lower second
// RULE4 - little-endian: lower halfword first, upper second
// RULE5 - long built from two halfwords, no swap
// RULE6 - opcode halfword sits in upper half
// RULE7 - halfwords consumed in ascending address order
// RULE8 - five-bit specifiers decode linearly to register
// RULE9 - short formats use three or five-bit specifiers
// RULE10 - major opcode is top six bits
// RULE11 - long specifiers five bits at fixed places
// RULE12 - split long instruction waits for second halfword
package mixed_length_fetch_decode_pkg;

	// ========================================================
	// widths and field positions
	localparam int          WORD_W      = 32;
	localparam int          HALF_W      = 16;
	localparam int          MAJOR_W     = 6;
	localparam int          MAJOR_LSB   = 26;
	localparam int          REG5_W      = 5;
	localparam int          REG3_W      = 3;
	localparam int          MINOR_W     = 10;
	// long formats: rt/rs/rd/rr lower edges
	localparam int          L_REG_A_LSB = 21;
	localparam int          L_REG_B_LSB = 16;
	localparam int          L_REG_C_LSB = 11;
	localparam int          L_REG_D_LSB = 6;
	// short formats, as held in the upper half of the assembled word
	localparam int          WIDE_REG_A_LSB   = 21;
	localparam int          WIDE_REG_B_LSB   = 16;
	localparam int          NARROW_REG_A_LSB = 23;
	localparam int          NARROW_REG_B_LSB = 20;
	localparam int          NARROW_REG_C_LSB = 17;
	// minor opcode field positions and widths
	localparam int          MINOR_HI_LSB  = 16;
	localparam int          MINOR_HI_W    = 10;
	localparam int          MINOR_MID_LSB = 12;
	localparam int          MINOR_MID_W   = 4;
	localparam int          MINOR_LO_LSB  = 0;
	localparam int          MINOR_LO_W    = 6;

	// ========================================================
	// per-major-opcode maps, bit n answers for opcode n
	localparam logic [63:0] SHORT_MAP     = 64'hFFFF_0000_0000_0000;
	localparam logic [63:0] WIDE_REG_MAP  = 64'h0F0F_0000_0000_0000;
	localparam logic [63:0] IMM_RIGHT_MAP = 64'h0000_FFFF_FF00_00FF;
	localparam logic [63:0] MINOR_SEL1    = 64'h0000_00FF_0000_FF00;
	localparam logic [63:0] MINOR_SEL0    = 64'h0000_F0F0_00FF_00F0;

	// minor opcode placement codes
	localparam logic [1:0]  MINOR_NONE = 2'h0;
	localparam logic [1:0]  MINOR_HI   = 2'h1;
	localparam logic [1:0]  MINOR_MID  = 2'h2;
	localparam logic [1:0]  MINOR_LO   = 2'h3;

	// ========================================================
	// fetch sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_WORD  = 3'h2,
		ST_SPLIT = 3'h4
	} fetch_state_e;

endpackage : mixed_length_fetch_decode_pkg

//--- hdl/mixed_length_fetch_decode.sv
// fetch word splitter, long instruction assembler and format decoder
module mixed_length_fetch_decode
	import mixed_length_fetch_decode_pkg::*;
(
	// clock, reset, enable
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire logic                 clk_en,
	// configuration pin, asynchronous
	input  wire logic                 big_endian,
	// fetch words from instruction memory
	input  wire logic                 fetch_valid,
	input  wire logic [WORD_W-1:0]    fetch_word,
	output logic                      fetch_ready,
	// decoded instruction stream
	output logic                      insn_valid,
	input  wire logic                 insn_ready,
	output logic [WORD_W-1:0]         insn,
	output logic                      insn_long,
	output logic [MAJOR_W-1:0]        insn_major,
	output logic [MINOR_W-1:0]        insn_minor,
	output logic [1:0]                insn_minor_sel,
	output logic                      insn_imm_right,
	output logic                      narrow_reg_format_prefix,
	output logic                      wide_reg_format_prefix,
	output logic [REG5_W-1:0]         reg_a,
	output logic [REG5_W-1:0]         reg_b,
	output logic [REG5_W-1:0]         reg_c,
	output logic [REG5_W-1:0]         reg_d
);

	// ========================================================
	// helpers

	// halfword idx 0 is the earlier one in address order
	function automatic logic [HALF_W-1:0] pick_half(input logic [WORD_W-1:0] w, input logic idx,
		input logic be);
		if (be ^ idx) begin
			pick_half = w[WORD_W-1:HALF_W]; // [RULE3] [RULE4]
		end else begin
			pick_half = w[HALF_W-1:0]; // [RULE3] [RULE4]
		end
	endfunction : pick_half

	// length from the opcode bits of the first halfword alone
	function automatic logic is_short(input logic [HALF_W-1:0] hw);
		is_short = SHORT_MAP[hw[HALF_W-1 -: MAJOR_W]]; // [RULE1] [RULE10]
	endfunction : is_short

	// ========================================================
	// configuration synchroniser
	logic be_meta_q;
	logic be_q;

	// pin is not on this clock, so two flops before use
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			be_meta_q <= 1'b0;
			be_q      <= 1'b0;
		end else if (clk_en) begin
			be_meta_q <= big_endian;
			be_q      <= be_meta_q;
		end
	end

	// ========================================================
	// sequencer
	fetch_state_e      state_q;
	logic [WORD_W-1:0] word_q;
	logic              ptr_q;
	logic [HALF_W-1:0] pend_q;
	logic              out_free;
	logic              take_fetch;
	logic              issue;
	logic [WORD_W-1:0] issue_insn;
	logic              issue_long;
	logic [HALF_W-1:0] cur_hw;
	logic [HALF_W-1:0] nxt_hw;
	logic [HALF_W-1:0] new_first;

	assign out_free  = !insn_valid || insn_ready;
	assign cur_hw    = pick_half(word_q, ptr_q, be_q);
	assign nxt_hw    = pick_half(word_q, 1'b1, be_q);
	assign new_first = pick_half(fetch_word, 1'b0, be_q);

	// a new word is accepted only when the held one is used up
	always_comb begin
		fetch_ready = 1'b0;
		if (clk_en) begin
			unique case (state_q)
				ST_IDLE:  fetch_ready = 1'b1;
				ST_SPLIT: fetch_ready = out_free; // [RULE12]
				ST_WORD:  fetch_ready = 1'b0;
			endcase
		end
	end
	assign take_fetch = fetch_valid && fetch_ready;

	// pick what goes out this cycle; long words keep opcode half on top
	always_comb begin
		issue      = 1'b0;
		issue_insn = '0;
		issue_long = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				issue = 1'b0;
			end
			ST_WORD: begin
				if (out_free && clk_en) begin
					if (is_short(cur_hw)) begin
						issue      = 1'b1;
						issue_insn = {cur_hw, {HALF_W{1'b0}}}; // [RULE10]
					end else if (!ptr_q) begin
						issue      = 1'b1;
						issue_long = 1'b1;
						issue_insn = {cur_hw, nxt_hw}; // [RULE5] [RULE6]
					end
				end
			end
			ST_SPLIT: begin
				if (take_fetch) begin
					issue      = 1'b1;
					issue_long = 1'b1;
					issue_insn = {pend_q, new_first}; // [RULE5] [RULE6] [RULE12]
				end
			end
		endcase
	end

	// state, held word and halfword pointer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			word_q  <= '0;
			ptr_q   <= 1'b0;
			pend_q  <= '0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_IDLE: begin
					if (take_fetch) begin
						state_q <= ST_WORD;
						word_q  <= fetch_word;
						ptr_q   <= 1'b0; // [RULE7]
					end
				end
				ST_WORD: begin
					if (out_free) begin
						if (is_short(cur_hw)) begin
							ptr_q <= 1'b1; // [RULE7]
							if (ptr_q) begin
								state_q <= ST_IDLE;
							end
						end else if (!ptr_q) begin
							state_q <= ST_IDLE;
						end else begin
							// second half lives in the next word: park it, issue nothing
							pend_q  <= cur_hw; // [RULE12]
							state_q <= ST_SPLIT;
						end
					end
				end
				ST_SPLIT: begin
					if (take_fetch) begin
						// first half of the new word is used; resume at its second
						word_q  <= fetch_word;
						ptr_q   <= 1'b1; // [RULE7]
						state_q <= ST_WORD;
					end
				end
			endcase
		end
	end

	// ========================================================
	// format decode of the assembled word
	logic [MAJOR_W-1:0] op;
	logic               op_wide;
	logic [1:0]         op_minor;
	logic [MINOR_W-1:0] minor_val;
	logic [REG5_W-1:0]  ra_d;
	logic [REG5_W-1:0]  rb_d;
	logic [REG5_W-1:0]  rc_d;
	logic [REG5_W-1:0]  rd_d;

	assign op       = issue_insn[MAJOR_LSB +: MAJOR_W]; // [RULE10]
	assign op_wide  = WIDE_REG_MAP[op];
	assign op_minor = issue_long ? {MINOR_SEL1[op], MINOR_SEL0[op]} : MINOR_NONE; // [RULE2]

	// minor opcode lifted from where the major opcode places it
	always_comb begin
		minor_val = '0;
		unique case (op_minor)
			MINOR_NONE: minor_val = '0;
			MINOR_HI:   minor_val = issue_insn[MINOR_HI_LSB +: MINOR_HI_W]; // [RULE2]
			MINOR_MID:  minor_val = {6'h00, issue_insn[MINOR_MID_LSB +: MINOR_MID_W]}; // [RULE2]
			MINOR_LO:   minor_val = {4'h0, issue_insn[MINOR_LO_LSB +: MINOR_LO_W]}; // [RULE2]
		endcase
	end

	// register specifiers: value is the register number, no remap here
	always_comb begin
		ra_d = '0;
		rb_d = '0;
		rc_d = '0;
		rd_d = '0;
		if (issue_long) begin
			ra_d = issue_insn[L_REG_A_LSB +: REG5_W]; // [RULE8] [RULE11]
			rb_d = issue_insn[L_REG_B_LSB +: REG5_W]; // [RULE8] [RULE11]
			rc_d = issue_insn[L_REG_C_LSB +: REG5_W]; // [RULE8] [RULE11]
			rd_d = issue_insn[L_REG_D_LSB +: REG5_W]; // [RULE8] [RULE11]
		end else if (op_wide) begin
			ra_d = issue_insn[WIDE_REG_A_LSB +: REG5_W]; // [RULE8] [RULE9]
			rb_d = issue_insn[WIDE_REG_B_LSB +: REG5_W]; // [RULE8] [RULE9]
		end else begin
			// compressed codes pass raw; the register mapping lives downstream
			ra_d = {2'h0, issue_insn[NARROW_REG_A_LSB +: REG3_W]}; // [RULE9]
			rb_d = {2'h0, issue_insn[NARROW_REG_B_LSB +: REG3_W]}; // [RULE9]
			rc_d = {2'h0, issue_insn[NARROW_REG_C_LSB +: REG3_W]}; // [RULE9]
		end
	end

	// ========================================================
	// output stage, all data from flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			insn_valid <= 1'b0;
		end else if (clk_en) begin
			if (issue) begin
				insn_valid <= 1'b1;
			end else if (insn_ready) begin
				insn_valid <= 1'b0;
			end
		end
	end

	// fields change only on issue so they stand until accepted
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			insn                     <= '0;
			insn_long                <= 1'b0;
			insn_major               <= '0;
			insn_minor               <= '0;
			insn_minor_sel           <= MINOR_NONE;
			insn_imm_right           <= 1'b0;
			narrow_reg_format_prefix <= 1'b0;
			wide_reg_format_prefix   <= 1'b0;
			reg_a                    <= '0;
			reg_b                    <= '0;
			reg_c                    <= '0;
			reg_d                    <= '0;
		end else if (clk_en && issue) begin
			insn                     <= issue_insn;
			insn_long                <= issue_long; // [RULE1]
			insn_major               <= op;
			insn_minor               <= minor_val;
			insn_minor_sel           <= op_minor;
			insn_imm_right           <= issue_long && IMM_RIGHT_MAP[op]; // [RULE2]
			narrow_reg_format_prefix <= !issue_long && !op_wide; // [RULE9]
			wide_reg_format_prefix   <= !issue_long && op_wide; // [RULE9]
			reg_a                    <= ra_d;
			reg_b                    <= rb_d;
			reg_c                    <= rc_d;
			reg_d                    <= rd_d;
		end
	end

endmodule : mixed_length_fetch_decode

//--- tb/mixed_length_fetch_decode_props.sv
// concurrent checks on the decoded instruction stream
module mixed_length_fetch_decode_props
	import mixed_length_fetch_decode_pkg::*;
(
	// clock, reset, enable
	input wire logic               clk_sys,
	input wire logic               rst_b,
	input wire logic               clk_en,
	// output handshake
	input wire logic               insn_valid,
	input wire logic               insn_ready,
	// decoded fields
	input wire logic [WORD_W-1:0]  insn,
	input wire logic               insn_long,
	input wire logic [MAJOR_W-1:0] insn_major,
	input wire logic [MINOR_W-1:0] insn_minor,
	input wire logic [1:0]         insn_minor_sel,
	input wire logic               insn_imm_right,
	input wire logic               narrow_reg_format_prefix,
	input wire logic               wide_reg_format_prefix,
	input wire logic [REG5_W-1:0]  reg_a,
	input wire logic [REG5_W-1:0]  reg_b,
	input wire logic [REG5_W-1:0]  reg_c,
	input wire logic [REG5_W-1:0]  reg_d
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// ========================================================
	// field checks while an instruction is presented
	property p_len; insn_valid |-> insn_long == !SHORT_MAP[insn_major]; endproperty
	a_len: assert property (p_len) else $error("length not from major opcode");
	property p_major; insn_valid |-> insn_major == insn[31:26]; endproperty
	a_major: assert property (p_major) else $error("major opcode not top six bits");
	property p_minor; insn_valid && insn_long |-> insn_minor_sel == {MINOR_SEL1[insn_major], MINOR_SEL0[insn_major]};
	endproperty
	a_minor: assert property (p_minor) else $error("minor placement wrong");
	// the minor value must be lifted, right-justified, from the field that its placement code names
	property p_minval; insn_valid |-> insn_minor == (insn_minor_sel == MINOR_HI ? insn[25:16]
		: insn_minor_sel == MINOR_MID ? {6'h00, insn[15:12]} : insn_minor_sel == MINOR_LO ? {4'h0, insn[5:0]} : 10'h000);
	endproperty
	a_minval: assert property (p_minval) else $error("minor field value wrong");
	property p_sreg; insn_valid && !insn_long |-> {reg_a, reg_b, reg_c, reg_d} == (WIDE_REG_MAP[insn_major]
		? {insn[25:16], 10'h000} : {2'h0, insn[25:23], 2'h0, insn[22:20], 2'h0, insn[19:17], 5'h00}); endproperty
	a_sreg: assert property (p_sreg) else $error("short register fields wrong");
	property p_imm; insn_valid |-> insn_imm_right == (insn_long && IMM_RIGHT_MAP[insn_major]); endproperty
	a_imm: assert property (p_imm) else $error("immediate alignment wrong");
	property p_lreg; insn_valid && insn_long |-> {reg_a, reg_b, reg_c, reg_d} == insn[25:6]; endproperty
	a_lreg: assert property (p_lreg) else $error("long register fields wrong");
	property p_fmt; insn_valid && !insn_long |-> wide_reg_format_prefix == WIDE_REG_MAP[insn_major]
		&& narrow_reg_format_prefix == !WIDE_REG_MAP[insn_major]; endproperty
	a_fmt: assert property (p_fmt) else $error("short format prefix wrong");
	property p_slow; insn_valid && !insn_long |-> insn[15:0] == 16'h0000; endproperty
	a_slow: assert property (p_slow) else $error("short lower half not clear");
	// an offered instruction must not change or vanish before it is taken
	property p_hold; insn_valid && !(insn_ready && clk_en) |=> insn_valid && $stable(insn); endproperty
	a_hold: assert property (p_hold) else $error("instruction dropped while stalled");
	c_long: cover property (insn_valid && insn_ready && insn_long);
	c_narrow: cover property (insn_valid && narrow_reg_format_prefix);
	c_stall: cover property (insn_valid && !insn_ready ##1 insn_valid);
	c_minor_lo: cover property (insn_valid && insn_minor_sel == MINOR_LO);
endmodule : mixed_length_fetch_decode_props

bind mixed_length_fetch_decode mixed_length_fetch_decode_props mixed_length_fetch_decode_props_i (.clk_sys, .rst_b,
	.clk_en, .insn_valid, .insn_ready, .insn, .insn_long, .insn_major, .insn_minor, .insn_minor_sel, .insn_imm_right,
	.narrow_reg_format_prefix, .wide_reg_format_prefix, .reg_a, .reg_b, .reg_c, .reg_d);

//--- tb/imem_model.sv
// instruction memory model handing out fetch words
module imem_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// bench control, zero words rewinds
	input  wire logic [3:0]  n_words,
	input  wire logic        slow,
	// fetch port
	input  wire logic        fetch_ready,
	output logic             fetch_valid,
	output logic [31:0]      fetch_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [0:15];
	logic [3:0]  ptr_q;
	logic        gap_q;
	// ========================================================
	// words leave in ascending address order, a slow memory idles after each
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q <= 4'h0;
			gap_q <= 1'b0;
		end else begin
			gap_q <= slow && fetch_valid && fetch_ready;
			if (n_words == 4'h0) ptr_q <= 4'h0;
			else if (fetch_valid && fetch_ready) ptr_q <= ptr_q + 4'h1;
		end
	end
	// idle bus shows the inverted word so stale data cannot pass
	assign fetch_valid = (ptr_q < n_words) && !gap_q;
	assign fetch_word  = fetch_valid ? mem[ptr_q] : ~mem[ptr_q];
endmodule : imem_model

//--- tb/tb_mixed_length_fetch_decode.sv
// self-checking bench for the mixed-length fetch and decode front end
module tb_mixed_length_fetch_decode
	import mixed_length_fetch_decode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk_sys, rst_b, clk_en, big_endian, insn_ready, slow;
	logic              fetch_valid, fetch_ready, insn_valid, insn_long;
	logic [31:0]       fetch_word, insn;
	logic [4:0]        reg_a;
	logic [9:0]        insn_minor;
	logic [3:0]        n_words;
	int                n_errors, checks;
	// programs: short, short, aligned long, short, long split over two words, short
	// the second one reaches wide shorts and the middle and low minor placements
	logic [15:0] prog [0:1][0:7] = '{
		'{16'hD2A5, 16'hC456, 16'h0021, 16'h3840, 16'hF00F, 16'h1234, 16'h5678, 16'hC0DE},
		'{16'hE1A3, 16'hFD27, 16'h2043, 16'hA5C0, 16'hC9F1, 16'h9234, 16'h56BF, 16'hC3C3}};
	logic [31:0] expw [0:1][0:5] = '{
		'{32'hD2A50000, 32'hC4560000, 32'h00213840, 32'hF00F0000, 32'h12345678, 32'hC0DE0000},
		'{32'hE1A30000, 32'hFD270000, 32'h2043A5C0, 32'hC9F10000, 32'h923456BF, 32'hC3C30000}};
	// minor value of the two longs and reg_a of the first long, per program
	logic [9:0]  expm [0:1][0:1] = '{'{10'h000, 10'h234}, '{10'h00A, 10'h03F}};
	logic [4:0]  expra [0:1] = '{5'h01, 5'h02};
	// ========================================================
	// design, memory model and clock
	mixed_length_fetch_decode mixed_length_fetch_decode_i (.clk_sys, .rst_b, .clk_en, .big_endian, .fetch_valid,
		.fetch_word, .fetch_ready, .insn_valid, .insn_ready, .insn, .insn_long, .insn_major(), .insn_minor,
		.insn_minor_sel(), .insn_imm_right(), .narrow_reg_format_prefix(), .wide_reg_format_prefix(), .reg_a,
		.reg_b(), .reg_c(), .reg_d());
	imem_model imem_model_i (.clk_sys, .rst_b, .n_words, .slow, .fetch_ready, .fetch_valid, .fetch_word);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// ========================================================
	// load the program in the chosen byte order, run it and compare the stream
	task automatic run(input logic be, input logic stall, input int sel);
		int n;
		n = 0;
		n_words <= 4'h0;
		big_endian <= be;
		@(posedge clk_sys);
		for (int k = 0; k < 4; k++) begin
			imem_model_i.mem[k] = be ? {prog[sel][2*k], prog[sel][2*k+1]} : {prog[sel][2*k+1], prog[sel][2*k]};
		end
		repeat (3) @(posedge clk_sys);
		slow <= stall;
		n_words <= 4'h4;
		// ready and enable go back high in the last pass so nothing is driven twice in one step
		for (int cyc = 0; cyc < 200 && n < 6; cyc++) begin
			@(posedge clk_sys);
			if (clk_en === 1'b0) check("fetch_ready", {31'h0, fetch_ready}, 32'h0);
			if (insn_valid === 1'b1 && insn_ready === 1'b1 && clk_en === 1'b1) begin
				check("insn", insn, expw[sel][n]);
				check("insn_long", {31'h0, insn_long}, {31'h0, n == 2 || n == 4});
				if (n == 2) check("reg_a", {27'h0, reg_a}, {27'h0, expra[sel]});
				if (n == 2 || n == 4) check("insn_minor", {22'h0, insn_minor}, {22'h0, expm[sel][n/2-1]});
				n++;
			end
			insn_ready <= (stall && n < 6) ? cyc[0] : 1'b1;
			clk_en <= !(stall && n < 6 && cyc >= 6 && cyc < 9);
		end
		if (n < 6) begin
			check("issued", n, 6);
			final_report();
		end
	endtask : run
	task automatic s_little_fast();
		run(1'b0, 1'b0, 0);
	endtask : s_little_fast
	// big order with a slow memory, a stalling consumer and a frozen enable
	task automatic s_big_stall();
		run(1'b1, 1'b1, 0);
	endtask : s_big_stall
	// wide shorts and the middle and low minor placements, big order then little with stalls
	task automatic s_alt_formats();
		run(1'b1, 1'b0, 1);
		run(1'b0, 1'b1, 1);
	endtask : s_alt_formats
	task automatic final_report();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		n_errors = 0;
		checks = 0;
		rst_b = 1'b0;
		clk_en = 1'b1;
		big_endian = 1'b0;
		insn_ready = 1'b1;
		slow = 1'b0;
		n_words = 4'h0;
		repeat (20) @(posedge clk_sys);
		rst_b <= 1'b1;
		s_little_fast();
		s_big_stall();
		s_little_fast();
		s_alt_formats();
		final_report();
	end
endmodule : tb_mixed_length_fetch_decode
